// [logic/parity_unit.sv]
// Parity generation and checking for one data word
module parity_unit #(
   parameter int DATA_W = 9
) (
   // Word and settings
   input wire logic [DATA_W-1:0] data_i,
   input wire logic odd_i,
   input wire logic gen_i,
   // Results
   output logic [DATA_W-1:0] word_o,
   output logic err_o
);

   logic gen_bit;

   // Top bit makes the total count of ones odd or even
   assign gen_bit = (^data_i[DATA_W-2:0]) ^ odd_i;
   assign word_o = gen_i ? {gen_bit, data_i[DATA_W-2:0]} : data_i;
   // No check while generating: the result would be meaningless
   assign err_o = ~gen_i & ((^data_i) != odd_i);

endmodule : parity_unit

// [logic/pin_sync.sv]
// Three-stage pin synchroniser with agreement filter and edge pulses
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Raw pins
   input wire logic [WIDTH-1:0] pin_i,
   // Filtered level and edges
   output logic [WIDTH-1:0] level_o,
   output logic [WIDTH-1:0] rise_o,
   output logic [WIDTH-1:0] fall_o
);

   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] lvl_q;
   logic [WIDTH-1:0] agree;

   // A change counts only once stages two and three agree
   assign agree = ~(s2_q ^ s3_q);
   assign rise_o = agree & s3_q & ~lvl_q;
   assign fall_o = agree & ~s3_q & lvl_q;
   assign level_o = lvl_q;

   // Stage one feeds stage two only
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
         lvl_q <= RST_VAL;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= (agree & s3_q) | (~agree & lvl_q);
      end
   end

endmodule : pin_sync

// [logic/ram_consts.svh]
// Register offsets, field positions and reset values of the memory block
`ifndef RAM_CONSTS_SVH
`define RAM_CONSTS_SVH

// Register byte offsets
`define RAM_CTRL_OFS 8'h00
`define RAM_THR_OFS 8'h04
`define RAM_STAT_OFS 8'h08
`define RAM_IRQ_STAT_OFS 8'h0C
`define RAM_IRQ_MASK_OFS 8'h10

// Control register fields
`define RAM_CTRL_MODE_LSB 0
`define RAM_CTRL_WR_ASYNC_BIT 2
`define RAM_CTRL_PAR_ODD_BIT 3
`define RAM_CTRL_PAR_GEN_BIT 4
`define RAM_CTRL_FIFO_EN_BIT 5

// Status register fields
`define RAM_STAT_EMPTY_BIT 0
`define RAM_STAT_FULL_BIT 1
`define RAM_STAT_EQ_BIT 2
`define RAM_STAT_GE_BIT 3
`define RAM_STAT_CNT_LSB 8

// Interrupt status and mask bits
`define RAM_IRQ_RPE_BIT 0
`define RAM_IRQ_WPE_BIT 1
`define RAM_IRQ_FULL_BIT 2
`define RAM_IRQ_EMPTY_BIT 3
`define RAM_IRQ_OVF_BIT 4
`define RAM_IRQ_W 5

// Reset values
`define RAM_CTRL_RST 6'h00
`define RAM_THR_RST 9'h080
`define RAM_IRQ_MASK_RST 5'h00
// Idle levels of the six strobe pins: clocks low, active-low strobes high
`define RAM_CTL_PIN_RST 6'h0F

`endif

// [logic/ram_types_pkg.sv]
// Types shared by the two-port memory block
package ram_types_pkg;

   // Read port timing modes
   typedef enum logic [1:0] {
      RD_TRANSPARENT = 2'b00,
      RD_PIPELINED = 2'b01,
      RD_ASYNC_ADDR = 2'b10,
      RD_ASYNC_PULSE = 2'b11
   } rd_mode_t;

endpackage : ram_types_pkg

// [logic/two_port_ram_fifo.sv]
// Two-port RAM/FIFO block with parity, sampled user ports, register file
`include "ram_consts.svh"

module two_port_ram_fifo #(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 9
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic nrst_i,
   // Write port pins
   input wire logic write_clock_i,
   input wire logic write_block_select_n_i,
   input wire logic write_pulse_n_i,
   input wire logic [ADDR_W-1:0] write_addr_i,
   input wire logic [DATA_W-1:0] write_data_in_i,
   // Read port pins
   input wire logic read_clock_i,
   input wire logic read_block_select_n_i,
   input wire logic read_pulse_n_i,
   input wire logic [ADDR_W-1:0] read_addr_i,
   // Read results and write parity error
   output logic [DATA_W-1:0] read_data_o,
   output logic read_parity_error_o,
   output logic write_parity_error_o,
   // FIFO flags
   output logic fifo_empty_o,
   output logic fifo_full_o,
   output logic threshold_equal_flag_o,
   output logic threshold_at_or_above_flag_o,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // Interrupt
   output logic irq_o
);

   localparam int DEPTH = 1 << ADDR_W;
   localparam int CW = ADDR_W + 1;

   // Parameter check
   generate
      if (ADDR_W < 1 || ADDR_W > 12 || DATA_W < 2 || DATA_W > 16) begin : g_bad
         $error("two_port_ram_fifo: unsupported ADDR_W or DATA_W");
      end
   endgenerate

   // Reset release through two flip-flops
   logic rst_s1_q;
   logic rst_n_q;
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   // Pin sampling; bus and strobes share the filter delay, so a user
   // must hold address and data stable around the strobe edges
   logic [5:0] ctl_lvl;
   logic [5:0] ctl_rise;
   logic [5:0] ctl_fall;
   logic [2*ADDR_W+DATA_W-1:0] bus_lvl;
   pin_sync #(.WIDTH(6), .RST_VAL(`RAM_CTL_PIN_RST)) u_ctl_sync (
      .clk_i(core_clk_i),
      .rst_n_i(rst_n_q),
      .pin_i({write_clock_i, read_clock_i, write_block_select_n_i,
              write_pulse_n_i, read_block_select_n_i, read_pulse_n_i}),
      .level_o(ctl_lvl),
      .rise_o(ctl_rise),
      .fall_o(ctl_fall)
   );
   pin_sync #(.WIDTH(2*ADDR_W+DATA_W)) u_bus_sync (
      .clk_i(core_clk_i),
      .rst_n_i(rst_n_q),
      .pin_i({write_addr_i, read_addr_i, write_data_in_i}),
      .level_o(bus_lvl),
      .rise_o(),
      .fall_o()
   );

   // Named views of the sampled pins
   wire wclk_rise = ctl_rise[5];
   wire rclk_rise = ctl_rise[4];
   wire rclk_fall = ctl_fall[4];
   wire wsel_n = ctl_lvl[3];
   wire wpulse_n = ctl_lvl[2];
   wire wpulse_rise = ctl_rise[2];
   wire rsel_n = ctl_lvl[1];
   wire rpulse_n = ctl_lvl[0];
   wire rpulse_fall = ctl_fall[0];
   wire [ADDR_W-1:0] write_addr_s = bus_lvl[2*ADDR_W+DATA_W-1 -: ADDR_W];
   wire [ADDR_W-1:0] read_addr_s = bus_lvl[ADDR_W+DATA_W-1 -: ADDR_W];
   wire [DATA_W-1:0] wdata_s = bus_lvl[DATA_W-1:0];

   // Control registers
   ram_types_pkg::rd_mode_t rd_mode_q;
   logic wr_async_q;
   logic par_odd_q;
   logic par_gen_q;
   logic fifo_en_q;
   logic [CW-1:0] thr_q;
   logic [`RAM_IRQ_W-1:0] mask_q;
   logic [`RAM_IRQ_W-1:0] irq_stat_q;
   logic [`RAM_IRQ_W-1:0] irq_stat_d;

   // Memory and FIFO state
   logic [DATA_W-1:0] mem [DEPTH];
   logic [ADDR_W-1:0] wptr_q;
   logic [ADDR_W-1:0] rptr_q;
   logic [CW-1:0] cnt_q;
   logic [ADDR_W-1:0] cap_addr_q;
   logic [DATA_W-1:0] cap_data_q;
   logic cap_v_q;

   // FIFO occupancy as seen by the core logic
   wire full_now = (cnt_q == CW'(DEPTH));
   wire empty_now = (cnt_q == '0);

   // Write request: write clock edge or rising write pulse
   wire wr_access = ~wsel_n & ~wpulse_n;
   wire wr_req_sync = ~wr_async_q & wclk_rise & wr_access;
   wire wr_req_async = wr_async_q & wpulse_rise & cap_v_q;
   wire wr_req = wr_req_sync | wr_req_async;
   wire wr_commit = wr_req & (~fifo_en_q | ~full_now);
   wire wr_overflow = wr_req & fifo_en_q & full_now;
   wire [DATA_W-1:0] wr_src = wr_async_q ? cap_data_q : wdata_s;
   wire [ADDR_W-1:0] wr_addr_c = fifo_en_q ? wptr_q :
                                 (wr_async_q ? cap_addr_q : write_addr_s);
   logic [DATA_W-1:0] wr_word_c;
   logic wr_chk_err;

   // Write side parity generation and check
   parity_unit #(.DATA_W(DATA_W)) u_wr_par (
      .data_i(wr_src),
      .odd_i(par_odd_q),
      .gen_i(par_gen_q),
      .word_o(wr_word_c),
      .err_o(wr_chk_err)
   );

   // Read address and word, with write-through on a same-address collision
   wire [ADDR_W-1:0] rd_addr_eff = fifo_en_q ? rptr_q : read_addr_s;
   wire wr_hit = wr_commit & (wr_addr_c == rd_addr_eff);
   wire [DATA_W-1:0] mem_word = mem[rd_addr_eff];
   wire [DATA_W-1:0] rd_word = wr_hit ? wr_word_c : mem_word;
   wire rd_active = ~rsel_n & ~rpulse_n;
   logic rd_chk_err;

   // Read side parity check only
   parity_unit #(.DATA_W(DATA_W)) u_rd_par (
      .data_i(rd_word),
      .odd_i(par_odd_q),
      .gen_i(1'b0),
      .word_o(),
      .err_o(rd_chk_err)
   );

   // Read acceptance per mode
   logic rd_take_ram;
   always_comb begin
      unique case (rd_mode_q)
         ram_types_pkg::RD_TRANSPARENT: rd_take_ram = rclk_rise & rd_active;
         ram_types_pkg::RD_PIPELINED: rd_take_ram = rclk_rise & rd_active;
         ram_types_pkg::RD_ASYNC_ADDR: rd_take_ram = rd_active;
         ram_types_pkg::RD_ASYNC_PULSE: begin
            rd_take_ram = (rpulse_fall & ~rsel_n) |
                          (rd_active & wr_hit);
         end
      endcase
   end
   // FIFO reads always go by the read clock edge
   wire rd_fifo_take = rclk_rise & rd_active & ~empty_now;
   wire rd_take = fifo_en_q ? rd_fifo_take : rd_take_ram;
   wire pipe_mode = (rd_mode_q == ram_types_pkg::RD_PIPELINED);
   wire push = fifo_en_q & wr_commit;
   wire pop = fifo_en_q & rd_take;

   // Memory array has no reset, like the hard block it models
   always_ff @(posedge core_clk_i) begin
      if (wr_commit) begin
         mem[wr_addr_c] <= wr_word_c;
      end
   end

   // Async write captures address and data each cycle while select and pulse are both low
   always_ff @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         cap_addr_q <= '0;
         cap_data_q <= '0;
         cap_v_q <= 1'b0;
      end else if (wr_access) begin
         cap_addr_q <= write_addr_s;
         cap_data_q <= wdata_s;
         cap_v_q <= 1'b1;
      end else begin
         // Select lifted mid-strobe drops the pending write
         cap_v_q <= 1'b0;
      end
   end

   // Write parity result, forced low while generating
   always_ff @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         write_parity_error_o <= 1'b0;
      end else if (wr_req) begin
         write_parity_error_o <= wr_chk_err;
      end
   end

   // Read output path: direct or through the pipeline stage
   logic [DATA_W-1:0] stage_q;
   logic stage_rpe_q;
   logic stage_v_q;
   always_ff @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         stage_q <= '0;
         stage_rpe_q <= 1'b0;
         stage_v_q <= 1'b0;
         read_data_o <= '0;
         read_parity_error_o <= 1'b0;
      end else if (pipe_mode) begin
         if (rclk_rise) begin
            stage_q <= rd_word;
            stage_rpe_q <= rd_chk_err;
            stage_v_q <= rd_take;
            if (stage_v_q) begin
               read_data_o <= stage_q;
               read_parity_error_o <= stage_rpe_q;
            end
         end
      end else if (rd_take) begin
         read_data_o <= rd_word;
         read_parity_error_o <= rd_chk_err;
         stage_v_q <= 1'b0;
      end
   end

   // FIFO pointers and count
   always_ff @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q <= '0;
      end else if (!fifo_en_q) begin
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q <= '0;
      end else begin
         wptr_q <= wptr_q + ADDR_W'(push);
         rptr_q <= rptr_q + ADDR_W'(pop);
         cnt_q <= cnt_q + CW'(push) - CW'(pop);
      end
   end

   // Flags move only on the falling read clock edge
   always_ff @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         fifo_empty_o <= 1'b1;
         fifo_full_o <= 1'b0;
         threshold_equal_flag_o <= 1'b0;
         threshold_at_or_above_flag_o <= 1'b0;
      end else if (rclk_fall) begin
         fifo_empty_o <= empty_now;
         fifo_full_o <= full_now;
         threshold_equal_flag_o <= (cnt_q == thr_q);
         threshold_at_or_above_flag_o <= (cnt_q >= thr_q);
      end
   end

   // Register decode
   wire sel_ctrl = (reg_addr_i == `RAM_CTRL_OFS);
   wire sel_thr = (reg_addr_i == `RAM_THR_OFS);
   wire sel_stat = (reg_addr_i == `RAM_STAT_OFS);
   wire sel_istat = (reg_addr_i == `RAM_IRQ_STAT_OFS);
   wire sel_mask = (reg_addr_i == `RAM_IRQ_MASK_OFS);
   wire [31:0] ctrl_rd = 32'({fifo_en_q, par_gen_q, par_odd_q, wr_async_q,
                              rd_mode_q});
   wire [31:0] stat_rd = (32'(cnt_q) << `RAM_STAT_CNT_LSB) |
                         32'({threshold_at_or_above_flag_o,
                              threshold_equal_flag_o, fifo_full_o,
                              fifo_empty_o});
   // Unmapped offsets read as zero
   wire [31:0] rd_mux = sel_ctrl ? ctrl_rd :
                        sel_thr ? 32'(thr_q) :
                        sel_stat ? stat_rd :
                        sel_istat ? 32'(irq_stat_q) :
                        sel_mask ? 32'(mask_q) : 32'h0000_0000;

   // Events: read error, write error, went full, went empty, overflow
   wire [`RAM_IRQ_W-1:0] irq_evt = {wr_overflow,
                                    rclk_fall & empty_now & ~fifo_empty_o,
                                    rclk_fall & full_now & ~fifo_full_o,
                                    wr_req & wr_chk_err,
                                    rd_take & rd_chk_err};
   // Read clears, but an event in the same cycle wins
   wire istat_clr = reg_rd_i & sel_istat;
   assign irq_stat_d = (istat_clr ? '0 : irq_stat_q) | irq_evt;

   // Register writes
   always_ff @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         {fifo_en_q, par_gen_q, par_odd_q, wr_async_q} <=
            4'(`RAM_CTRL_RST >> 2);
         rd_mode_q <= ram_types_pkg::RD_TRANSPARENT;
         thr_q <= CW'(`RAM_THR_RST);
         mask_q <= `RAM_IRQ_MASK_RST;
      end else if (reg_wr_i) begin
         if (sel_ctrl) begin
            rd_mode_q <= ram_types_pkg::rd_mode_t'(reg_wdata_i[1:0]);
            wr_async_q <= reg_wdata_i[`RAM_CTRL_WR_ASYNC_BIT];
            par_odd_q <= reg_wdata_i[`RAM_CTRL_PAR_ODD_BIT];
            par_gen_q <= reg_wdata_i[`RAM_CTRL_PAR_GEN_BIT];
            fifo_en_q <= reg_wdata_i[`RAM_CTRL_FIFO_EN_BIT];
         end
         if (sel_thr) begin
            thr_q <= reg_wdata_i[CW-1:0];
         end
         if (sel_mask) begin
            mask_q <= reg_wdata_i[`RAM_IRQ_W-1:0];
         end
      end
   end

   // Read data, interrupt status and interrupt line
   always_ff @(posedge core_clk_i or negedge rst_n_q) begin
      if (!rst_n_q) begin
         reg_rdata_o <= 32'h0000_0000;
         irq_stat_q <= '0;
         irq_o <= 1'b0;
      end else begin
         reg_rdata_o <= reg_rd_i ? rd_mux : 32'h0000_0000;
         irq_stat_q <= irq_stat_d;
         irq_o <= |(irq_stat_d & mask_q);
      end
   end

   // Checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_q);

   chk_sync_write_commit: assert property (
      (~wr_async_q & ~fifo_en_q & wclk_rise & wr_access)
      |=> mem[$past(write_addr_s)] == $past(wr_word_c))
      else $error("sync write not stored");
   chk_async_write_commit: assert property (
      (wr_async_q & ~fifo_en_q & wpulse_rise & cap_v_q)
      |=> mem[$past(cap_addr_q)] == $past(wr_word_c))
      else $error("async write not committed on pulse rise");
   chk_transparent_read: assert property (
      (rd_mode_q == ram_types_pkg::RD_TRANSPARENT && rd_take)
      |=> read_data_o == $past(rd_word))
      else $error("transparent read data late or wrong");
   chk_pipe_read_stage: assert property (
      (pipe_mode && rclk_rise && stage_v_q)
      |=> read_data_o == $past(stage_q))
      else $error("pipelined read not shown at second edge");
   chk_rd_parity_err: assert property (
      (~pipe_mode && rd_take) |=> read_parity_error_o == $past(rd_chk_err))
      else $error("read parity error wrong");
   chk_wr_parity_err: assert property (
      (wr_req && !par_gen_q)
      |=> write_parity_error_o == ((^$past(wr_src)) != $past(par_odd_q)))
      else $error("write parity error wrong");
   chk_parity_gen_odd: assert property (
      (wr_commit && par_gen_q) |-> (^wr_word_c) == par_odd_q)
      else $error("generated parity has wrong polarity");
   chk_wpe_gen_quiet: assert property (
      (wr_req && par_gen_q) |=> !write_parity_error_o)
      else $error("write parity error raised while generating");
   chk_async_refresh: assert property (
      (rd_mode_q == ram_types_pkg::RD_ASYNC_PULSE && ~fifo_en_q &&
       rd_active && wr_hit) |=> read_data_o == $past(wr_word_c))
      else $error("write to read address did not refresh output");
   chk_addr_follow: assert property (
      (rd_mode_q == ram_types_pkg::RD_ASYNC_ADDR && ~fifo_en_q && rd_active)
      |=> read_data_o == $past(rd_word))
      else $error("async address read did not follow");
   chk_flags_on_fall: assert property (
      !rclk_fall |=> $stable(fifo_full_o) && $stable(fifo_empty_o))
      else $error("FIFO flag moved off the falling read edge");
   chk_collision_bypass: assert property (
      (rd_take && wr_hit && ~pipe_mode) |=> read_data_o == $past(wr_word_c))
      else $error("collision did not pass write data through");

endmodule : two_port_ram_fifo

// [sim/test_two_port_ram_fifo.sv]
// Self-checking bench for the two-port memory block
`include "ram_consts.svh"
module test_two_port_ram_fifo;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [5:0] ctrl;
      logic [7:0] addr;
      logic [8:0] data;
   } row_t;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata, v;
   logic wclk, wsel_n, wpul_n, rclk, rsel_n, rpul_n;
   logic [7:0] write_addr, read_addr;
   logic [8:0] wdata, rdata;
   logic read_parity_error, write_parity_error, empty, full, eq, ge, irq;
   int miscompares = 0;
   int samples_checked = 0;
   int cycles = 0;
   // Ctrl, address, data: even, odd, generated parity
   row_t rows [6] = '{'{6'h00, 8'h00, 9'h000}, '{6'h00, 8'hFF, 9'h1FF},
      '{6'h08, 8'h01, 9'h001}, '{6'h08, 8'h80, 9'h0A5},
      '{6'h10, 8'h02, 9'h13C}, '{6'h18, 8'h7F, 9'h007}};

   always #2 core_clk = ~core_clk;

   user_logic_model u_user_logic_model (.core_clk_i(core_clk),
      .write_clock_o(wclk), .write_block_select_n_o(wsel_n),
      .write_pulse_n_o(wpul_n), .write_addr_o(write_addr),
      .write_data_in_o(wdata), .read_clock_o(rclk),
      .read_block_select_n_o(rsel_n), .read_pulse_n_o(rpul_n),
      .read_addr_o(read_addr));

   two_port_ram_fifo u_two_port_ram_fifo (.core_clk_i(core_clk),
      .nrst_i(nrst), .write_clock_i(wclk), .write_block_select_n_i(wsel_n),
      .write_pulse_n_i(wpul_n), .write_addr_i(write_addr),
      .write_data_in_i(wdata), .read_clock_i(rclk),
      .read_block_select_n_i(rsel_n), .read_pulse_n_i(rpul_n),
      .read_addr_i(read_addr), .read_data_o(rdata), .read_parity_error_o(read_parity_error),
      .write_parity_error_o(write_parity_error), .fifo_empty_o(empty), .fifo_full_o(full),
      .threshold_equal_flag_o(eq), .threshold_at_or_above_flag_o(ge),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
      .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .irq_o(irq));

   // Stored word: generated parity replaces bit 8
   function automatic logic [8:0] exp_word(input row_t r);
      return r.ctrl[4] ? {^r.data[7:0] ^ r.ctrl[3], r.data[7:0]} : r.data;
   endfunction : exp_word

   task automatic check(input string name, input logic [31:0] seen,
         input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic end_of_test();
      if (miscompares == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test

   // Register bus: one-cycle strobes, read data only the cycle after
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : reg_read

   // Hang guard, well above the expected run length
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         end_of_test();
      end
   end

   initial begin
      repeat (20) @(posedge core_clk);
      check("empty in reset", empty, 1'b1);
      check("irq in reset", irq, 1'b0);
      nrst <= 1'b1;
      repeat (10) @(posedge core_clk);
      reg_read(`RAM_CTRL_OFS, v);
      check("ctrl reset", v, 32'h0);
      reg_read(`RAM_THR_OFS, v);
      check("thr reset", v, 32'h80);
      reg_read(`RAM_IRQ_MASK_OFS, v);
      check("mask reset", v, 32'h0);
      reg_read(8'h14, v);
      check("unmapped", v, 32'h0);
      // Ordinary transparent write and read-back rows
      foreach (rows[i]) begin
         reg_write(`RAM_CTRL_OFS, 32'(rows[i].ctrl));
         u_user_logic_model.write_word(rows[i].addr, rows[i].data, 1'b0,
            1'b1);
         check("write parity", write_parity_error, rows[i].ctrl[4] ? 1'b0 :
            ^rows[i].data ^ rows[i].ctrl[3]);
         u_user_logic_model.read_word(rows[i].addr, 1'b0);
         check("read data", rdata, exp_word(rows[i]));
         check("read parity", read_parity_error,
            ^exp_word(rows[i]) ^ rows[i].ctrl[3]);
      end
      // Deselected write and deselected read change nothing
      reg_write(`RAM_CTRL_OFS, 32'h0);
      u_user_logic_model.write_word(8'h00, 9'h0AA, 1'b1, 1'b1);
      u_user_logic_model.read_word(8'h00, 1'b1);
      check("no read", rdata, 9'h007);
      u_user_logic_model.read_word(8'h00, 1'b0);
      check("no write", rdata, 9'h000);
      // Strobe-timed write, then read back
      reg_write(`RAM_CTRL_OFS, 32'h4);
      u_user_logic_model.write_word(8'h10, 9'h055, 1'b0, 1'b0);
      reg_write(`RAM_CTRL_OFS, 32'h0);
      u_user_logic_model.read_word(8'h10, 1'b0);
      check("async write", rdata, 9'h055);
      // Pipelined: data lands only at the following read edge
      reg_write(`RAM_CTRL_OFS, 32'(ram_types_pkg::RD_PIPELINED));
      u_user_logic_model.read_word(8'h01, 1'b0);
      check("pipe first", rdata, 9'h055);
      u_user_logic_model.read_word(8'h10, 1'b0);
      check("pipe second", rdata, 9'h001);
      // Address-following read
      reg_write(`RAM_CTRL_OFS, 32'(ram_types_pkg::RD_ASYNC_ADDR));
      u_user_logic_model.hold_read(8'hFF);
      check("addr read a", rdata, 9'h1FF);
      u_user_logic_model.hold_read(8'h80);
      check("addr read b", rdata, 9'h0A5);
      u_user_logic_model.release_read();
      // A write to the open address refreshes the output
      reg_write(`RAM_CTRL_OFS, 32'(ram_types_pkg::RD_ASYNC_PULSE));
      u_user_logic_model.hold_read(8'h02);
      check("pulse read", rdata, 9'h03C);
      u_user_logic_model.write_word(8'h02, 9'h0F0, 1'b0, 1'b1);
      check("refresh", rdata, 9'h0F0);
      u_user_logic_model.release_read();
      // Interrupt: masked, unmasked, cleared by status read
      reg_write(`RAM_CTRL_OFS, 32'h0);
      reg_read(`RAM_IRQ_STAT_OFS, v);
      u_user_logic_model.write_word(8'h20, 9'h001, 1'b0, 1'b1);
      check("irq masked", irq, 1'b0);
      reg_write(`RAM_IRQ_MASK_OFS, 32'h2);
      repeat (2) @(posedge core_clk);
      check("irq raised", irq, 1'b1);
      reg_read(`RAM_IRQ_STAT_OFS, v);
      check("irq status", v, 32'h2);
      repeat (2) @(posedge core_clk);
      check("irq cleared", irq, 1'b0);
      // FIFO flags move on read clock fall
      reg_write(`RAM_THR_OFS, 32'h2);
      reg_write(`RAM_CTRL_OFS, 32'h20);
      u_user_logic_model.write_word(8'h00, 9'h011, 1'b0, 1'b1);
      u_user_logic_model.write_word(8'h00, 9'h022, 1'b0, 1'b1);
      u_user_logic_model.read_word(8'h00, 1'b1);
      check("fifo flags two", {empty, full, eq, ge}, 4'b0011);
      u_user_logic_model.read_word(8'h00, 1'b0);
      check("fifo flags one", {empty, full, eq, ge}, 4'b0000);
      check("fifo read", rdata, 9'h011);
      end_of_test();
   end
endmodule : test_two_port_ram_fifo

// [sim/user_logic_model.sv]
// Behavioural model of the user core logic driving both memory ports
module user_logic_model (
   // Core clock that paces every pin change
   input wire logic core_clk_i,
   // Write port pins
   output logic write_clock_o,
   output logic write_block_select_n_o,
   output logic write_pulse_n_o,
   output logic [7:0] write_addr_o,
   output logic [8:0] write_data_in_o,
   // Read port pins
   output logic read_clock_o,
   output logic read_block_select_n_o,
   output logic read_pulse_n_o,
   output logic [7:0] read_addr_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Idle pins: clocks low, strobes and selects high
   initial begin
      write_clock_o = 1'b0;
      write_block_select_n_o = 1'b1;
      write_pulse_n_o = 1'b1;
      write_addr_o = 8'h00;
      write_data_in_o = 9'h000;
      read_clock_o = 1'b0;
      read_block_select_n_o = 1'b1;
      read_pulse_n_o = 1'b1;
      read_addr_o = 8'h00;
   end

   // Four core cycles per phase keeps the synchroniser margin
   task automatic pace(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask : pace

   // One write; unclocked means the strobe rise commits it
   task automatic write_word(input logic [7:0] a, input logic [8:0] d,
         input logic sel_n, input logic clocked);
      @(posedge core_clk_i);
      write_block_select_n_o <= sel_n;
      write_pulse_n_o <= 1'b0;
      write_addr_o <= a;
      write_data_in_o <= d;
      pace(4);
      if (clocked) begin
         write_clock_o <= 1'b1;
         pace(4);
         write_clock_o <= 1'b0;
         pace(4);
      end
      write_pulse_n_o <= 1'b1;
      pace(4);
      write_block_select_n_o <= 1'b1;
      // Released bus shows no stale value
      write_addr_o <= ~a;
      write_data_in_o <= ~d;
      pace(4);
   endtask : write_word

   // One clocked read; a high select leaves only the clock edges
   task automatic read_word(input logic [7:0] a, input logic sel_n);
      @(posedge core_clk_i);
      read_block_select_n_o <= sel_n;
      read_pulse_n_o <= 1'b0;
      read_addr_o <= a;
      pace(4);
      read_clock_o <= 1'b1;
      pace(4);
      read_clock_o <= 1'b0;
      pace(4);
      read_block_select_n_o <= 1'b1;
      read_pulse_n_o <= 1'b1;
      read_addr_o <= ~a;
      pace(4);
   endtask : read_word

   // Unclocked read held open on one address
   task automatic hold_read(input logic [7:0] a);
      @(posedge core_clk_i);
      read_block_select_n_o <= 1'b0;
      read_addr_o <= a;
      pace(4);
      // Select and address settle before the pulse falls
      read_pulse_n_o <= 1'b0;
      pace(8);
   endtask : hold_read

   // Close an unclocked read
   task automatic release_read();
      @(posedge core_clk_i);
      read_block_select_n_o <= 1'b1;
      read_pulse_n_o <= 1'b1;
      read_addr_o <= ~read_addr_o;
      pace(4);
   endtask : release_read
endmodule : user_logic_model
